// ---- design/sep_pkg.sv ----
// Purpose: Shared constants for the two-wire serial memory link
// Assumes: 250 MHz system clock on both ends
// Notes: Times are given in their own unit, cycle counts derived
`default_nettype none
package sep_pkg;
  localparam int CLK_MHZ = 250;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int MEM_WORDS = 256;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [6:0] UPPER_ADDR_DEF = 7'h50;
  localparam int PROG_ONE_MS = 20;
  localparam int PROG_TWO_MS = 40;
  localparam int PROG_ONE_CYC = PROG_ONE_MS * 1000 * CLK_MHZ;
  localparam int PROG_TWO_CYC = PROG_TWO_MS * 1000 * CLK_MHZ;
  localparam int SCL_HALF_NS = 5000;
  localparam int SCL_HALF_CYC = (SCL_HALF_NS * CLK_MHZ) / 1000;
  typedef enum logic [1:0] {
    SEP_OP_WRITE1,
    SEP_OP_WRITE2,
    SEP_OP_READ_AT,
    SEP_OP_READ_CUR
  } sep_op_t;
endpackage
`default_nettype wire

// ---- design/sep_link_if.sv ----
// Purpose: Two-wire link joining master and memory ends
// Assumes: Open-drain lines with pull-ups; enables are active low
// Notes: A line is low when any end drives it
`default_nettype none
interface sep_link_if;
  logic scl_o;
  logic scl_oe_n;
  logic sda_m_o;
  logic sda_m_oe_n;
  logic sda_s_o;
  logic sda_s_oe_n;
  wire scl = (!scl_oe_n && !scl_o) ? 1'b0 : 1'b1;
  wire sda = ((!sda_m_oe_n && !sda_m_o) || (!sda_s_oe_n && !sda_s_o)) ? 1'b0 : 1'b1;
  modport master (output scl_o, output scl_oe_n, output sda_m_o, output sda_m_oe_n, input scl, input sda);
  modport memory (output sda_s_o, output sda_s_oe_n, input scl, input sda);
endinterface
`default_nettype wire

// ---- design/sep_eeprom_slave.sv ----
// Purpose: Memory end of the two-wire serial link, 256 words of 8 bits
// Assumes: Link lines sampled by mclk, far slower than mclk
// Notes: Program cycle time is modelled by a busy counter
`default_nettype none
module sep_eeprom_slave
  import sep_pkg::*;
#(
  parameter logic [6:0] UPPER_ADDR = UPPER_ADDR_DEF,
  parameter int PROG_ONE = PROG_ONE_CYC,
  parameter int PROG_TWO = PROG_TWO_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Straps
  input wire logic [2:0] chip_select_straps,
  // Status
  output logic prog_busy,
  output logic [ADDR_W-1:0] word_address_value,
  // Link
  sep_link_if.memory link
);
  // ****************************************
  // Input synchronisers and edge detection
  // ****************************************
  logic [1:0] scl_sync, sda_sync;
  logic scl_q, sda_q;
  // Two-flop sampling works at any bus rate far below mclk
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (clk_en) begin
      scl_sync <= {scl_sync[0], link.scl};
      sda_sync <= {sda_sync[0], link.sda};
      scl_q <= scl_sync[1];
      sda_q <= sda_sync[1];
    end
  end
  wire scl_s = scl_sync[1];
  wire sda_s = sda_sync[1];
  wire scl_rise = scl_s && !scl_q;
  wire scl_fall = !scl_s && scl_q;
  wire start_det = scl_s && scl_q && sda_q && !sda_s;
  wire stop_det = scl_s && scl_q && !sda_q && sda_s;

  // ****************************************
  // Byte engine
  // ****************************************
  typedef enum logic [2:0] {ST_IDLE, ST_DEVADDR, ST_WORDADDR, ST_WDATA, ST_RDATA, ST_RACK, ST_IGNORE}
    sep_state_t;
  sep_state_t state;
  logic [2:0] bit_cnt;
  logic ack_phase;
  logic [DATA_W-1:0] shreg;
  logic [ADDR_W-1:0] ptr;
  logic [1:0] wr_count;
  logic sda_drive_low;
  logic [DATA_W-1:0] mem [MEM_WORDS];
  logic [31:0] busy_cnt;

  wire byte_done = scl_rise && !ack_phase && bit_cnt == BIT_LAST;
  wire [DATA_W-1:0] rx_byte = {shreg[DATA_W-2:0], sda_s};
  wire addr_match = rx_byte[7:1] == {UPPER_ADDR[6:3], chip_select_straps};
  wire rd_bit = rx_byte[0];
  wire writing = state == ST_WDATA;
  wire tx_bit = shreg[DATA_W-1];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      bit_cnt <= 3'h0;
      ack_phase <= 1'b0;
      shreg <= 8'h00;
      ptr <= 8'h00;
      wr_count <= 2'h0;
      sda_drive_low <= 1'b0;
    end else if (clk_en) begin
      if (start_det && busy_cnt == 32'h0) begin
        state <= ST_DEVADDR;
        bit_cnt <= 3'h0;
        ack_phase <= 1'b0;
        wr_count <= 2'h0;
        sda_drive_low <= 1'b0;
      end else if (stop_det || start_det) begin
        state <= ST_IDLE;
        sda_drive_low <= 1'b0;
      end else if (scl_rise && ack_phase && state == ST_RACK) begin
        if (!sda_s) begin
          ptr <= ptr + 8'h01;
          shreg <= mem[ptr + 8'h01];
          state <= ST_RDATA;
        end else begin
          state <= ST_IGNORE;
        end
        ack_phase <= 1'b0;
        bit_cnt <= 3'h0;
      end else if (scl_rise && !ack_phase) begin
        if (state != ST_RDATA) shreg <= rx_byte;
        else shreg <= {shreg[DATA_W-2:0], 1'b1};
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == BIT_LAST) begin
          ack_phase <= 1'b1;
          case (state)
            ST_DEVADDR: begin
              if (!addr_match) state <= ST_IGNORE;
              else if (rd_bit) state <= ST_RDATA;
              else state <= ST_WORDADDR;
            end
            ST_WORDADDR: begin
              ptr <= rx_byte;
              state <= ST_WDATA;
            end
            ST_WDATA: begin
              if (wr_count < 2'h2) begin
                mem[ptr] <= rx_byte;
                ptr <= ptr + 8'h01;
                wr_count <= wr_count + 2'h1;
              end
            end
            ST_RDATA: state <= ST_RACK;
            default: state <= state;
          endcase
        end
      end else if (scl_rise && ack_phase) begin
        if (state == ST_RDATA) shreg <= mem[ptr];
        ack_phase <= 1'b0;
        bit_cnt <= 3'h0;
      end else if (scl_fall) begin
        if (ack_phase && state != ST_IGNORE && state != ST_RACK && state != ST_IDLE) begin
          sda_drive_low <= 1'b1;
        end else if (state == ST_RDATA && !ack_phase) begin
          sda_drive_low <= !tx_bit;
        end else begin
          sda_drive_low <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // Program cycle timer
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt <= 32'h0;
    end else if (clk_en) begin
      if (stop_det && writing && wr_count != 2'h0) begin
        busy_cnt <= (wr_count == 2'h1) ? 32'(PROG_ONE) : 32'(PROG_TWO);
      end else if (busy_cnt != 32'h0) begin
        busy_cnt <= busy_cnt - 32'h1;
      end
    end
  end

  assign prog_busy = busy_cnt != 32'h0;
  assign word_address_value = ptr;
  assign link.sda_s_o = 1'b0;
  assign link.sda_s_oe_n = !sda_drive_low;
endmodule // sep_eeprom_slave
`default_nettype wire

// ---- design/sep_link_master.sv ----
// Purpose: Master end of the two-wire serial link
// Assumes: Operations fit in one request; SCL made by divider
// Notes: One operation moves one or two bytes
`default_nettype none
module sep_link_master
  import sep_pkg::*;
#(
  parameter int HALF = SCL_HALF_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Request
  input wire logic req_valid,
  output logic req_ready,
  input wire sep_op_t req_op,
  input wire logic [2:0] req_chip,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata0,
  input wire logic [DATA_W-1:0] req_wdata1,
  input wire logic [1:0] req_rd_count,
  // Answer
  output logic rsp_valid,
  output logic rsp_nack,
  output logic [DATA_W-1:0] rsp_rdata0,
  output logic [DATA_W-1:0] rsp_rdata1,
  // Link
  sep_link_if.master link
);
  // ****************************************
  // Bit sequencer: one entry per bit slot
  // ****************************************
  typedef enum logic [2:0] {M_IDLE, M_START, M_BITS, M_RSTART, M_STOP, M_DONE} sep_mst_t;
  sep_mst_t st;
  logic [15:0] div;
  logic [1:0] phase;
  logic [5:0] slot;
  logic [5:0] last_slot;
  logic [53:0] tx;
  logic [53:0] drive;
  logic [5:0] rs_slot;
  logic sda_o, scl_o;
  logic nack;
  logic [15:0] rx;
  logic [1:0] sda_sync;
  logic op_rd, cnt2;
  wire tick = div == 16'(HALF - 1);
  wire [5:0] data_start = last_slot - (cnt2 ? 6'd17 : 6'd8);
  wire [6:0] dev = {UPPER_ADDR_DEF[6:3], req_chip};
  wire is_rd = req_op == SEP_OP_READ_AT || req_op == SEP_OP_READ_CUR;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sda_sync <= 2'h3;
    end else if (clk_en) begin
      sda_sync <= {sda_sync[0], link.sda};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= M_IDLE;
      div <= 16'h0;
      phase <= 2'h0;
      slot <= 6'h0;
      last_slot <= 6'h0;
      rs_slot <= 6'h3f;
      tx <= '1;
      drive <= '0;
      sda_o <= 1'b1;
      scl_o <= 1'b1;
      nack <= 1'b0;
      op_rd <= 1'b0;
      cnt2 <= 1'b0;
      rx <= 16'h0;
      rsp_valid <= 1'b0;
      rsp_nack <= 1'b0;
      rsp_rdata0 <= 8'h00;
      rsp_rdata1 <= 8'h00;
    end else if (clk_en) begin
      rsp_valid <= 1'b0;
      div <= tick ? 16'h0 : div + 16'h1;
      case (st)
        M_IDLE: begin
          div <= 16'h0;
          if (req_valid) begin
            nack <= 1'b0;
            slot <= 6'h0;
            op_rd <= is_rd;
            cnt2 <= req_rd_count[1];
            st <= M_START;
            // Slots of 9 bits, first slot at the top: byte then acknowledge bit (1 = released)
            case (req_op)
              SEP_OP_WRITE1: begin
                tx <= {dev, 1'b0, 1'b1, req_addr, 1'b1, req_wdata0, 1'b1, {27{1'b1}}};
                last_slot <= 6'd26;
                rs_slot <= 6'h3f;
              end
              SEP_OP_WRITE2: begin
                tx <= {dev, 1'b0, 1'b1, req_addr, 1'b1, req_wdata0, 1'b1, req_wdata1, 1'b1, {18{1'b1}}};
                last_slot <= 6'd35;
                rs_slot <= 6'h3f;
              end
              SEP_OP_READ_AT: begin
                tx <= {dev, 1'b0, 1'b1, req_addr, 1'b1, dev, 1'b1, 1'b1, 8'hff, ~req_rd_count[1], 8'hff, 1'b1,
                  {9{1'b1}}};
                last_slot <= req_rd_count[1] ? 6'd44 : 6'd35;
                rs_slot <= 6'd18;
              end
              default: begin
                tx <= {dev, 1'b1, 1'b1, 8'hff, ~req_rd_count[1], 8'hff, 1'b1, {27{1'b1}}};
                last_slot <= req_rd_count[1] ? 6'd26 : 6'd17;
                rs_slot <= 6'h3f;
              end
            endcase
          end
        end
        M_START: if (tick) begin
          sda_o <= 1'b0; // START while clock high
          st <= M_BITS;
          phase <= 2'h0;
        end
        M_BITS: if (tick) begin
          phase <= phase + 2'h1;
          case (phase)
            2'h0: begin
              scl_o <= 1'b0;
            end
            2'h1: begin
              sda_o <= tx[6'd53 - slot];
            end
            2'h2: begin
              scl_o <= 1'b1;
              if (slot % 6'd9 == 6'd8 && (!op_rd || slot < data_start))
                nack <= nack | sda_sync[1];
              if (op_rd && slot >= data_start && slot % 6'd9 != 6'd8)
                rx <= {rx[14:0], sda_sync[1]};
            end
            default: begin
              phase <= 2'h0;
              slot <= slot + 6'h1;
              if (slot == last_slot) st <= M_STOP;
              else if (slot + 6'h1 == rs_slot) st <= M_RSTART;
            end
          endcase
        end
        M_RSTART: if (tick) begin
          phase <= phase + 2'h1;
          case (phase)
            2'h0: scl_o <= 1'b0;
            2'h1: sda_o <= 1'b1;
            2'h2: scl_o <= 1'b1;
            default: begin
              sda_o <= 1'b0;
              phase <= 2'h0;
              st <= M_BITS;
            end
          endcase
        end
        M_STOP: if (tick) begin
          phase <= phase + 2'h1;
          case (phase)
            2'h0: scl_o <= 1'b0;
            2'h1: sda_o <= 1'b0;
            2'h2: scl_o <= 1'b1;
            default: begin
              sda_o <= 1'b1; // STOP
              st <= M_DONE;
            end
          endcase
        end
        M_DONE: begin
          rsp_valid <= 1'b1;
          rsp_nack <= nack;
          rsp_rdata0 <= cnt2 ? rx[15:8] : rx[7:0];
          rsp_rdata1 <= rx[7:0];
          st <= M_IDLE;
        end
        default: st <= M_IDLE;
      endcase
    end
  end

  assign req_ready = st == M_IDLE;
  assign link.scl_o = 1'b0;
  assign link.scl_oe_n = scl_o;
  assign link.sda_m_o = 1'b0;
  assign link.sda_m_oe_n = sda_o;
endmodule // sep_link_master
`default_nettype wire

// ---- tb/sep_link_monitor.sv ----
// Purpose: Protocol checks on the link between the master and memory ends
// Assumes: Lines sampled by mclk, far faster than the line rate
// Notes: Bit index restarts at START; nine clock pulses per byte
`default_nettype none
module sep_link_monitor #(
  parameter int HALF = 25
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Drivers and resolved lines
  input wire logic scl_o,
  input wire logic scl_oe_n,
  input wire logic sda_m_o,
  input wire logic sda_m_oe_n,
  input wire logic sda_s_o,
  input wire logic sda_s_oe_n,
  input wire logic scl,
  input wire logic sda
);
  // ****************
  // Frame tracking
  // ****************
  logic scl_q, sda_q, in_frame, quiet;
  logic [3:0] bit_idx;
  logic [15:0] lvl_cnt;
  wire start_w = scl && scl_q && sda_q && !sda;
  wire stop_w = scl && scl_q && !sda_q && sda;
  wire rise_w = scl && !scl_q;
  wire fall_w = !scl && scl_q;
  wire slave_low = !sda_s_oe_n && !sda_s_o;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      in_frame <= 1'b0;
      quiet <= 1'b0;
      bit_idx <= 4'h0;
      lvl_cnt <= 16'h0000;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      in_frame <= start_w || (in_frame && !stop_w);
      quiet <= !start_w && (quiet || (rise_w && bit_idx == 4'h8 && sda));
      bit_idx <= start_w ? 4'h0 : (rise_w ? ((bit_idx == 4'h8) ? 4'h0 : bit_idx + 4'h1) : bit_idx);
      lvl_cnt <= (scl != scl_q) ? 16'h0000 : ((lvl_cnt == 16'hffff) ? lvl_cnt : lvl_cnt + 16'h0001);
    end
  end
  // ****************
  // Assertions
  // ****************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_slave_edge; $changed(slave_low) |-> !scl; endproperty
  a_slave_edge: assert property (p_slave_edge) else $error("memory end moved data with clock high");
  property p_slave_frame; slave_low |-> in_frame; endproperty
  a_slave_frame: assert property (p_slave_frame) else $error("memory end drove data outside a frame");
  property p_nack_quiet; quiet |-> !slave_low; endproperty
  a_nack_quiet: assert property (p_nack_quiet) else $error("memory end drove data after no-acknowledge");
  property p_frame_whole; stop_w |-> bit_idx == 4'h1; endproperty
  a_frame_whole: assert property (p_frame_whole) else $error("frame ended off a byte boundary");
  property p_scl_idle; !in_frame |-> (scl_oe_n || scl_o); endproperty
  a_scl_idle: assert property (p_scl_idle) else $error("clock driven low outside a frame");
  property p_scl_low; rise_w |-> lvl_cnt >= HALF - 2; endproperty
  a_scl_low: assert property (p_scl_low) else $error("clock low phase too short");
  property p_scl_high; fall_w && in_frame |-> lvl_cnt >= HALF - 2; endproperty
  a_scl_high: assert property (p_scl_high) else $error("clock high phase too short");
  property p_ack_hold; scl && scl_q && bit_idx == 4'h0 && in_frame && !start_w |-> sda == sda_q; endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("data moved during acknowledge clock high");
  c_start: cover property (start_w);
  c_ack: cover property (rise_w && bit_idx == 4'h8 && !sda);
  c_nack: cover property (rise_w && bit_idx == 4'h8 && sda);
endmodule // sep_link_monitor
`default_nettype wire

// ---- tb/tb_i2c_serial_eeprom_slave.sv ----
// Purpose: Self-checking bench for both link ends joined by the interface
// Assumes: Short bit and program times set by parameters
// Notes: Memory contents and pointer tracked by a bench model
`default_nettype none
module tb_i2c_serial_eeprom_slave import sep_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 25;
  localparam int P1 = 200;
  localparam int P2 = 400;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  sep_op_t req_op = SEP_OP_WRITE1;
  logic [2:0] req_chip = 3'h0;
  logic [2:0] straps = 3'h0;
  logic [7:0] req_addr = 8'h00;
  logic [7:0] req_wdata0 = 8'h00;
  logic [7:0] req_wdata1 = 8'h00;
  logic [1:0] req_rd_count = 2'h1;
  logic req_ready, rsp_valid, rsp_nack, prog_busy;
  logic [7:0] rsp_rdata0, rsp_rdata1, ptr;
  logic [15:0] lfsr = 16'h4aae;
  int n_fail = 0;
  int checked = 0;
  int mem[int];
  sep_link_if link();
  sep_eeprom_slave #(.PROG_ONE(P1), .PROG_TWO(P2)) i_sep_eeprom_slave (.mclk(mclk), .rst_n(rst_n),
    .clk_en(1'b1), .chip_select_straps(straps), .prog_busy(prog_busy), .word_address_value(ptr), .link(link));
  sep_link_master #(.HALF(HALF)) i_sep_link_master (.mclk(mclk), .rst_n(rst_n), .clk_en(1'b1),
    .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_chip(req_chip), .req_addr(req_addr),
    .req_wdata0(req_wdata0), .req_wdata1(req_wdata1), .req_rd_count(req_rd_count), .rsp_valid(rsp_valid),
    .rsp_nack(rsp_nack), .rsp_rdata0(rsp_rdata0), .rsp_rdata1(rsp_rdata1), .link(link));
  sep_link_monitor #(.HALF(HALF)) i_sep_link_monitor (.mclk(mclk), .rst_n(rst_n), .scl_o(link.scl_o),
    .scl_oe_n(link.scl_oe_n), .sda_m_o(link.sda_m_o), .sda_m_oe_n(link.sda_m_oe_n), .sda_s_o(link.sda_s_o),
    .sda_s_oe_n(link.sda_s_oe_n), .scl(link.scl), .sda(link.sda));
  always #2 mclk = ~mclk;
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("Checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // One whole operation: request held until taken, then wait for the answer
  task automatic run_op(input sep_op_t op, input logic [2:0] chip, input logic [7:0] a, input logic [7:0] d0,
                        input logic [7:0] d1, input logic [1:0] cnt);
    int n;
    n = 0;
    while (req_ready !== 1'b1) begin
      @(posedge mclk);
      #1;
    end
    req_op = op;
    req_chip = chip;
    req_addr = a;
    req_wdata0 = d0;
    req_wdata1 = d1;
    req_rd_count = cnt;
    req_valid = 1'b1;
    @(posedge mclk);
    #1 req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 30000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 30000) check("rsp_wait", 16'h1, 16'h0);
  endtask
  task automatic busy_len(output int n);
    n = 0;
    // The memory end sees STOP a few cycles after the answer
    while (prog_busy !== 1'b1 && n < 20) begin
      @(posedge mclk);
      #1;
      n++;
    end
    n = 0;
    while (prog_busy !== 1'b0 && n < 5000) begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask
  // ****************
  // Main sequence
  // ****************
  initial begin
    logic [7:0] a, d0, d1, lp;
    int n;
    repeat (3) @(posedge mclk);
    #1 rst_n = 1'b1;
    for (int it = 0; it < 3; it++) begin
      lfsr = nx(lfsr);
      a = (it == 0) ? 8'hff : lfsr[7:0];
      d0 = lfsr[15:8];
      lfsr = nx(lfsr);
      d1 = lfsr[7:0];
      straps = lfsr[10:8];
      lp = a + 8'h01;
      run_op(SEP_OP_WRITE2, straps, a, d0, d1, 2'h1);
      mem[a] = d0;
      mem[lp] = d1;
      check("wr2_nack", rsp_nack, 16'h0);
      busy_len(n);
      check("wr2_time", (n > P2 - 20 && n < P2 + 20), 16'h1);
      run_op(SEP_OP_READ_AT, straps, a, 8'h00, 8'h00, 2'h2);
      check("rd_b0", rsp_rdata0, mem[a]);
      check("rd_b1", rsp_rdata1, mem[lp]);
      check("rd_ptr", ptr, lp);
      run_op(SEP_OP_READ_CUR, straps, 8'h00, 8'h00, 8'h00, 2'h1);
      check("cur_b0", rsp_rdata0, mem[lp]);
      check("cur_ptr", ptr, lp);
      run_op(SEP_OP_WRITE1, straps ^ 3'h4, 8'h00, d1, 8'h00, 2'h1);
      check("bad_nack", rsp_nack, 16'h1);
      check("bad_ptr", {ptr, prog_busy}, {lp, 1'b0});
      run_op(SEP_OP_WRITE1, straps, a, d1, 8'h00, 2'h1);
      mem[a] = d1;
      check("wr1_nack", rsp_nack, 16'h0);
      check("wr1_ptr", ptr, lp);
      if (it == 0) begin
        busy_len(n);
        check("wr1_time", (n > P1 - 20 && n < P1 + 20), 16'h1);
      end else begin
        run_op(SEP_OP_READ_CUR, straps, 8'h00, 8'h00, 8'h00, 2'h1);
        check("busy_nack", rsp_nack, 16'h1);
        busy_len(n);
      end
    end
    run_op(SEP_OP_READ_AT, straps, a, 8'h00, 8'h00, 2'h1);
    check("rd_wr1", rsp_rdata0, mem[a]);
    close_out();
  end
  // Whole run is about 60000 cycles; cut off well beyond that
  initial begin
    #(4 * 95000);
    n_fail++;
    close_out();
  end
endmodule // tb_i2c_serial_eeprom_slave
`default_nettype wire
